/* File: hdl/ife_irq_regs.svh */
// Register offsets, field positions, masks and reset values of the flag/enable block
`ifndef IFE_IRQ_REGS_SVH
`define IFE_IRQ_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the APB
// ----------------------------------------------------------------------------
`define IFE_OFF_FLAG_STATUS_5 12'h000
`define IFE_OFF_FLAG_STATUS_6 12'h004
`define IFE_OFF_FLAG_STATUS_7 12'h008
`define IFE_OFF_ENABLE_CTRL_0 12'h00c
`define IFE_OFF_ENABLE_CTRL_1 12'h010

// ----------------------------------------------------------------------------
// Reset value and implemented-bit masks
// ----------------------------------------------------------------------------
`define IFE_RESET_VALUE 16'h0000
`define IFE_MASK_FLAG_STATUS_5 16'he01e
`define IFE_MASK_FLAG_STATUS_6 16'hc3ff
`define IFE_MASK_FLAG_STATUS_7 16'h003f
`define IFE_MASK_ENABLE_CTRL_0 16'h7fff
`define IFE_MASK_ENABLE_CTRL_1 16'hff1f

// ----------------------------------------------------------------------------
// Field positions, flag_status_5
// ----------------------------------------------------------------------------
`define IFE_POS_PWM_GEN_TWO_FLAG 15
`define IFE_POS_PWM_GEN_ONE_FLAG 14
`define IFE_POS_ADC_PAIR_TWELVE_DONE_FLAG 13
`define IFE_POS_ADC_PAIR_ELEVEN_DONE_FLAG 4
`define IFE_POS_ADC_PAIR_TEN_DONE_FLAG 3
`define IFE_POS_ADC_PAIR_NINE_DONE_FLAG 2
`define IFE_POS_ADC_PAIR_EIGHT_DONE_FLAG 1

// ----------------------------------------------------------------------------
// Field positions, flag_status_6 and flag_status_7
// ----------------------------------------------------------------------------
`define IFE_POS_ADC_PAIR_ONE_DONE_FLAG 15
`define IFE_POS_ADC_PAIR_ZERO_DONE_FLAG 14
`define IFE_POS_COMPARATOR_FOUR_FLAG 9
`define IFE_POS_COMPARATOR_THREE_FLAG 8
`define IFE_POS_COMPARATOR_TWO_FLAG 7
`define IFE_POS_PWM_GEN_NINE_FLAG 6
`define IFE_POS_PWM_GEN_EIGHT_FLAG 5
`define IFE_POS_PWM_GEN_SEVEN_FLAG 4
`define IFE_POS_PWM_GEN_SIX_FLAG 3
`define IFE_POS_PWM_GEN_FIVE_FLAG 2
`define IFE_POS_PWM_GEN_FOUR_FLAG 1
`define IFE_POS_PWM_GEN_THREE_FLAG 0
`define IFE_POS_ADC_PAIR_SEVEN_DONE_FLAG 5
`define IFE_POS_ADC_PAIR_SIX_DONE_FLAG 4
`define IFE_POS_ADC_PAIR_FIVE_DONE_FLAG 3
`define IFE_POS_ADC_PAIR_FOUR_DONE_FLAG 2
`define IFE_POS_ADC_PAIR_THREE_DONE_FLAG 1
`define IFE_POS_ADC_PAIR_TWO_DONE_FLAG 0

// ----------------------------------------------------------------------------
// Field positions, enable_control_0
// ----------------------------------------------------------------------------
`define IFE_POS_DMA_CH_ONE_DONE_ENABLE 14
`define IFE_POS_ADC_CONVERT_DONE_ENABLE 13
`define IFE_POS_UART_ONE_TX_ENABLE 12
`define IFE_POS_UART_ONE_RX_ENABLE 11
`define IFE_POS_SPI_ONE_EVENT_ENABLE 10
`define IFE_POS_SPI_ONE_FAULT_ENABLE 9
`define IFE_POS_TIMER_THREE_ENABLE 8
`define IFE_POS_TIMER_TWO_ENABLE 7
`define IFE_POS_COMPARE_TWO_ENABLE 6
`define IFE_POS_CAPTURE_TWO_ENABLE 5
`define IFE_POS_DMA_CH_ZERO_DONE_ENABLE 4
`define IFE_POS_TIMER_ONE_ENABLE 3
`define IFE_POS_COMPARE_ONE_ENABLE 2
`define IFE_POS_CAPTURE_ONE_ENABLE 1
`define IFE_POS_EXT_IRQ_ZERO_ENABLE 0

// ----------------------------------------------------------------------------
// Field positions, enable_control_1
// ----------------------------------------------------------------------------
`define IFE_POS_UART_TWO_TX_ENABLE 15
`define IFE_POS_UART_TWO_RX_ENABLE 14
`define IFE_POS_EXT_IRQ_TWO_ENABLE 13
`define IFE_POS_TIMER_FIVE_ENABLE 12
`define IFE_POS_TIMER_FOUR_ENABLE 11
`define IFE_POS_COMPARE_FOUR_ENABLE 10
`define IFE_POS_COMPARE_THREE_ENABLE 9
`define IFE_POS_DMA_CH_TWO_DONE_ENABLE 8
`define IFE_POS_EXT_IRQ_ONE_ENABLE 4
`define IFE_POS_PIN_CHANGE_NOTIFY_ENABLE 3
`define IFE_POS_COMPARATOR_ONE_ENABLE 2
`define IFE_POS_I2C_ONE_MASTER_ENABLE 1
`define IFE_POS_I2C_ONE_SLAVE_ENABLE 0

`endif

/* File: hdl/ife_pkg.sv */
// Types shared by the flag/enable register block
package ife_pkg;
  typedef logic [15:0] ife_half_t;
  typedef logic [31:0] ife_data_t;
  typedef logic [11:0] ife_addr_t;
endpackage

/* File: hdl/ife_reg16.sv */
// One 16-bit flag or enable register with hardware set and software write
`timescale 1ns/100ps
`default_nettype none
`include "ife_irq_regs.svh"
module ife_reg16 #(
  parameter logic [15:0] MASK = 16'hffff
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_wr_en,
  input wire ife_pkg::ife_half_t i_wdata,
  input wire ife_pkg::ife_half_t i_set,
  output var ife_pkg::ife_half_t o_value
);
  import ife_pkg::*;

  ife_half_t value_d;
  ife_half_t wr_val;

  // Unimplemented bits never store
  assign wr_val = i_wr_en ? (i_wdata & MASK) : o_value;
  // Hardware set wins over a software clear in the same cycle
  assign value_d = wr_val | (i_set & MASK);

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      o_value <= `IFE_RESET_VALUE;
    else
      o_value <= value_d;
  end
endmodule
`default_nettype wire

/* File: hdl/ife_irq_regs.sv */
// Interrupt flag status 5..7 and enable control 0..1 registers behind an APB slave
//
// Contract
// (R01) A flag bit reads one after its source requested, zero otherwise.
// (R02) An enable bit at one passes its source request, at zero blocks it.
// (R03) Unimplemented bits read zero and ignore writes.
// (R04) flag_status_5: pwm two bit 15, pwm one bit 14, adc pair twelve bit 13.
// (R05) flag_status_5: adc pairs eleven..eight at bits 4..1; 12..5 and 0 unused.
// (R06) flag_status_6: adc pairs one/zero 15/14, comparators four..two 9..7.
// (R07) flag_status_6: pwm generators nine..three at bits 6..0.
// (R08) flag_status_7: adc pairs seven..two at bits 5..0; 15..6 unused.
// (R09) enable_control_0: uart one tx bit 12, uart one rx bit 11.
// (R10) enable_control_0: spi one event bit 10, spi one fault bit 9.
// (R11) enable_control_0: ext irq zero, capture, compare, timer one at 0..3.
// (R12) enable_control_0: dma one bit 14, adc done bit 13, bit 15 unused.
// (R13) enable_control_1: dma two bit 8, compare three 9, compare four 10.
// (R14) enable_control_1: uart two tx bit 15, uart two rx bit 14.
// (R15) enable_control_1: irq two, timers 13..11; 7..5 unused; 4..2 irq one etc.
// (R16) enable_control_1: i2c one master bit 1, slave bit 0.
// (R17) All bits reset to zero and stay software readable and writable; the code masks unimplemented bits, which ignore writes.
// (R18) A request goes out only while both flag and enable are set.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ife_irq_regs.svh"
module ife_irq_regs (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire ife_pkg::ife_addr_t i_paddr,
  input wire ife_pkg::ife_data_t i_pwdata,
  output var ife_pkg::ife_data_t o_prdata,
  output var logic o_pready,
  output var logic o_pslverr,
  input wire ife_pkg::ife_half_t i_flag_set5,
  input wire ife_pkg::ife_half_t i_flag_set6,
  input wire ife_pkg::ife_half_t i_flag_set7,
  input wire ife_pkg::ife_half_t i_far_enable5,
  input wire ife_pkg::ife_half_t i_far_enable6,
  input wire ife_pkg::ife_half_t i_far_enable7,
  input wire ife_pkg::ife_half_t i_far_flag0,
  input wire ife_pkg::ife_half_t i_far_flag1,
  output var ife_pkg::ife_half_t o_flag5,
  output var ife_pkg::ife_half_t o_flag6,
  output var ife_pkg::ife_half_t o_flag7,
  output var ife_pkg::ife_half_t o_enable0,
  output var ife_pkg::ife_half_t o_enable1,
  output var ife_pkg::ife_half_t o_irq_req5,
  output var ife_pkg::ife_half_t o_irq_req6,
  output var ife_pkg::ife_half_t o_irq_req7,
  output var ife_pkg::ife_half_t o_irq_req0,
  output var ife_pkg::ife_half_t o_irq_req1
);
  import ife_pkg::*;

  localparam int NREG = 5;

  // --------------------------------------------------------------------------
  // Register layout
  // --------------------------------------------------------------------------
  localparam ife_half_t REG_MASK [NREG] = '{
    `IFE_MASK_FLAG_STATUS_5, // R04 R05
    `IFE_MASK_FLAG_STATUS_6, // R06 R07
    `IFE_MASK_FLAG_STATUS_7, // R08
    `IFE_MASK_ENABLE_CTRL_0, // R09 R10 R11 R12
    `IFE_MASK_ENABLE_CTRL_1 // R13 R14 R15 R16
  };
  localparam ife_addr_t REG_OFF [NREG] = '{
    `IFE_OFF_FLAG_STATUS_5,
    `IFE_OFF_FLAG_STATUS_6,
    `IFE_OFF_FLAG_STATUS_7,
    `IFE_OFF_ENABLE_CTRL_0,
    `IFE_OFF_ENABLE_CTRL_1
  };

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  logic [NREG-1:0] hit;
  logic [NREG-1:0] wr_en;
  ife_half_t reg_q [NREG];
  ife_half_t set_vec [NREG];
  logic setup_phase;
  logic access_done;
  logic any_hit;
  ife_half_t rd_half;
  ife_data_t prdata_d;
  logic pready_d;
  logic pslverr_d;

  assign setup_phase = i_psel & ~i_penable;
  assign access_done = i_psel & i_penable & o_pready;
  assign any_hit = |hit;

  assign set_vec[0] = i_flag_set5; // R01
  assign set_vec[1] = i_flag_set6; // R01
  assign set_vec[2] = i_flag_set7; // R01
  assign set_vec[3] = '0;
  assign set_vec[4] = '0;

  // --------------------------------------------------------------------------
  // Register bank
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : gen_reg
      assign hit[g] = (i_paddr == REG_OFF[g]);
      // Write lands only at the completing access edge
      assign wr_en[g] = access_done & i_pwrite & hit[g]; // R17
      ife_reg16 #(
        .MASK(REG_MASK[g]) // R03
      ) u_reg (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_wr_en(wr_en[g]),
        .i_wdata(i_pwdata[15:0]),
        .i_set(set_vec[g]),
        .o_value(reg_q[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read data, ready and error
  // --------------------------------------------------------------------------
  assign rd_half = hit[0] ? reg_q[0] :
                   hit[1] ? reg_q[1] :
                   hit[2] ? reg_q[2] :
                   hit[3] ? reg_q[3] :
                   hit[4] ? reg_q[4] : '0; // R03
  assign prdata_d = (setup_phase & ~i_pwrite) ? {16'h0000, rd_half} : o_prdata;
  // One wait-free access: ready for exactly the access cycle
  assign pready_d = setup_phase;
  assign pslverr_d = setup_phase & ~any_hit;

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_prdata <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_prdata <= prdata_d;
      o_pready <= pready_d;
      o_pslverr <= pslverr_d;
    end
  end

  // --------------------------------------------------------------------------
  // Named fields of the register bank
  // --------------------------------------------------------------------------
  logic pwm_gen_two_flag;
  logic pwm_gen_one_flag;
  logic adc_pair_twelve_done_flag;
  logic adc_pair_eleven_done_flag;
  logic adc_pair_ten_done_flag;
  logic adc_pair_nine_done_flag;
  logic adc_pair_eight_done_flag;
  logic adc_pair_one_done_flag;
  logic adc_pair_zero_done_flag;
  logic comparator_four_flag;
  logic comparator_three_flag;
  logic comparator_two_flag;
  logic pwm_gen_nine_flag;
  logic pwm_gen_eight_flag;
  logic pwm_gen_seven_flag;
  logic pwm_gen_six_flag;
  logic pwm_gen_five_flag;
  logic pwm_gen_four_flag;
  logic pwm_gen_three_flag;
  logic adc_pair_seven_done_flag;
  logic adc_pair_six_done_flag;
  logic adc_pair_five_done_flag;
  logic adc_pair_four_done_flag;
  logic adc_pair_three_done_flag;
  logic adc_pair_two_done_flag;
  logic dma_ch_one_done_enable;
  logic adc_convert_done_enable;
  logic uart_one_tx_enable;
  logic uart_one_rx_enable;
  logic spi_one_event_enable;
  logic spi_one_fault_enable;
  logic timer_three_enable;
  logic timer_two_enable;
  logic compare_two_enable;
  logic capture_two_enable;
  logic dma_ch_zero_done_enable;
  logic timer_one_enable;
  logic compare_one_enable;
  logic capture_one_enable;
  logic ext_irq_zero_enable;
  logic uart_two_tx_enable;
  logic uart_two_rx_enable;
  logic ext_irq_two_enable;
  logic timer_five_enable;
  logic timer_four_enable;
  logic compare_four_enable;
  logic compare_three_enable;
  logic dma_ch_two_done_enable;
  logic ext_irq_one_enable;
  logic pin_change_notify_enable;
  logic comparator_one_enable;
  logic i2c_one_master_enable;
  logic i2c_one_slave_enable;

  assign pwm_gen_two_flag = reg_q[0][`IFE_POS_PWM_GEN_TWO_FLAG];
  assign pwm_gen_one_flag = reg_q[0][`IFE_POS_PWM_GEN_ONE_FLAG];
  assign adc_pair_twelve_done_flag = reg_q[0][`IFE_POS_ADC_PAIR_TWELVE_DONE_FLAG];
  assign adc_pair_eleven_done_flag = reg_q[0][`IFE_POS_ADC_PAIR_ELEVEN_DONE_FLAG];
  assign adc_pair_ten_done_flag = reg_q[0][`IFE_POS_ADC_PAIR_TEN_DONE_FLAG];
  assign adc_pair_nine_done_flag = reg_q[0][`IFE_POS_ADC_PAIR_NINE_DONE_FLAG];
  assign adc_pair_eight_done_flag = reg_q[0][`IFE_POS_ADC_PAIR_EIGHT_DONE_FLAG];
  assign adc_pair_one_done_flag = reg_q[1][`IFE_POS_ADC_PAIR_ONE_DONE_FLAG];
  assign adc_pair_zero_done_flag = reg_q[1][`IFE_POS_ADC_PAIR_ZERO_DONE_FLAG];
  assign comparator_four_flag = reg_q[1][`IFE_POS_COMPARATOR_FOUR_FLAG];
  assign comparator_three_flag = reg_q[1][`IFE_POS_COMPARATOR_THREE_FLAG];
  assign comparator_two_flag = reg_q[1][`IFE_POS_COMPARATOR_TWO_FLAG];
  assign pwm_gen_nine_flag = reg_q[1][`IFE_POS_PWM_GEN_NINE_FLAG];
  assign pwm_gen_eight_flag = reg_q[1][`IFE_POS_PWM_GEN_EIGHT_FLAG];
  assign pwm_gen_seven_flag = reg_q[1][`IFE_POS_PWM_GEN_SEVEN_FLAG];
  assign pwm_gen_six_flag = reg_q[1][`IFE_POS_PWM_GEN_SIX_FLAG];
  assign pwm_gen_five_flag = reg_q[1][`IFE_POS_PWM_GEN_FIVE_FLAG];
  assign pwm_gen_four_flag = reg_q[1][`IFE_POS_PWM_GEN_FOUR_FLAG];
  assign pwm_gen_three_flag = reg_q[1][`IFE_POS_PWM_GEN_THREE_FLAG];
  assign adc_pair_seven_done_flag = reg_q[2][`IFE_POS_ADC_PAIR_SEVEN_DONE_FLAG];
  assign adc_pair_six_done_flag = reg_q[2][`IFE_POS_ADC_PAIR_SIX_DONE_FLAG];
  assign adc_pair_five_done_flag = reg_q[2][`IFE_POS_ADC_PAIR_FIVE_DONE_FLAG];
  assign adc_pair_four_done_flag = reg_q[2][`IFE_POS_ADC_PAIR_FOUR_DONE_FLAG];
  assign adc_pair_three_done_flag = reg_q[2][`IFE_POS_ADC_PAIR_THREE_DONE_FLAG];
  assign adc_pair_two_done_flag = reg_q[2][`IFE_POS_ADC_PAIR_TWO_DONE_FLAG];
  assign dma_ch_one_done_enable = reg_q[3][`IFE_POS_DMA_CH_ONE_DONE_ENABLE];
  assign adc_convert_done_enable = reg_q[3][`IFE_POS_ADC_CONVERT_DONE_ENABLE];
  assign uart_one_tx_enable = reg_q[3][`IFE_POS_UART_ONE_TX_ENABLE];
  assign uart_one_rx_enable = reg_q[3][`IFE_POS_UART_ONE_RX_ENABLE];
  assign spi_one_event_enable = reg_q[3][`IFE_POS_SPI_ONE_EVENT_ENABLE];
  assign spi_one_fault_enable = reg_q[3][`IFE_POS_SPI_ONE_FAULT_ENABLE];
  assign timer_three_enable = reg_q[3][`IFE_POS_TIMER_THREE_ENABLE];
  assign timer_two_enable = reg_q[3][`IFE_POS_TIMER_TWO_ENABLE];
  assign compare_two_enable = reg_q[3][`IFE_POS_COMPARE_TWO_ENABLE];
  assign capture_two_enable = reg_q[3][`IFE_POS_CAPTURE_TWO_ENABLE];
  assign dma_ch_zero_done_enable = reg_q[3][`IFE_POS_DMA_CH_ZERO_DONE_ENABLE];
  assign timer_one_enable = reg_q[3][`IFE_POS_TIMER_ONE_ENABLE];
  assign compare_one_enable = reg_q[3][`IFE_POS_COMPARE_ONE_ENABLE];
  assign capture_one_enable = reg_q[3][`IFE_POS_CAPTURE_ONE_ENABLE];
  assign ext_irq_zero_enable = reg_q[3][`IFE_POS_EXT_IRQ_ZERO_ENABLE];
  assign uart_two_tx_enable = reg_q[4][`IFE_POS_UART_TWO_TX_ENABLE];
  assign uart_two_rx_enable = reg_q[4][`IFE_POS_UART_TWO_RX_ENABLE];
  assign ext_irq_two_enable = reg_q[4][`IFE_POS_EXT_IRQ_TWO_ENABLE];
  assign timer_five_enable = reg_q[4][`IFE_POS_TIMER_FIVE_ENABLE];
  assign timer_four_enable = reg_q[4][`IFE_POS_TIMER_FOUR_ENABLE];
  assign compare_four_enable = reg_q[4][`IFE_POS_COMPARE_FOUR_ENABLE];
  assign compare_three_enable = reg_q[4][`IFE_POS_COMPARE_THREE_ENABLE];
  assign dma_ch_two_done_enable = reg_q[4][`IFE_POS_DMA_CH_TWO_DONE_ENABLE];
  assign ext_irq_one_enable = reg_q[4][`IFE_POS_EXT_IRQ_ONE_ENABLE];
  assign pin_change_notify_enable = reg_q[4][`IFE_POS_PIN_CHANGE_NOTIFY_ENABLE];
  assign comparator_one_enable = reg_q[4][`IFE_POS_COMPARATOR_ONE_ENABLE];
  assign i2c_one_master_enable = reg_q[4][`IFE_POS_I2C_ONE_MASTER_ENABLE];
  assign i2c_one_slave_enable = reg_q[4][`IFE_POS_I2C_ONE_SLAVE_ENABLE];

  // --------------------------------------------------------------------------
  // Register contents out, unused positions tied low
  // --------------------------------------------------------------------------
  assign o_flag5 = {pwm_gen_two_flag, pwm_gen_one_flag, adc_pair_twelve_done_flag, // R04
                    8'h00, adc_pair_eleven_done_flag, adc_pair_ten_done_flag, // R05
                    adc_pair_nine_done_flag, adc_pair_eight_done_flag, 1'h0};
  assign o_flag6 = {adc_pair_one_done_flag, adc_pair_zero_done_flag, 4'h0, // R06
                    comparator_four_flag, comparator_three_flag, comparator_two_flag,
                    pwm_gen_nine_flag, pwm_gen_eight_flag, pwm_gen_seven_flag, // R07
                    pwm_gen_six_flag, pwm_gen_five_flag, pwm_gen_four_flag, pwm_gen_three_flag};
  assign o_flag7 = {10'h000, adc_pair_seven_done_flag, adc_pair_six_done_flag, // R08
                    adc_pair_five_done_flag, adc_pair_four_done_flag,
                    adc_pair_three_done_flag, adc_pair_two_done_flag};
  assign o_enable0 = {1'h0, dma_ch_one_done_enable, adc_convert_done_enable, // R12
                      uart_one_tx_enable, uart_one_rx_enable, // R09
                      spi_one_event_enable, spi_one_fault_enable, // R10
                      timer_three_enable, timer_two_enable, compare_two_enable,
                      capture_two_enable, dma_ch_zero_done_enable,
                      timer_one_enable, compare_one_enable, // R11
                      capture_one_enable, ext_irq_zero_enable};
  assign o_enable1 = {uart_two_tx_enable, uart_two_rx_enable, // R14
                      ext_irq_two_enable, timer_five_enable, timer_four_enable, // R15
                      compare_four_enable, compare_three_enable, dma_ch_two_done_enable, // R13
                      3'h0, ext_irq_one_enable, pin_change_notify_enable, comparator_one_enable,
                      i2c_one_master_enable, i2c_one_slave_enable}; // R16

  // --------------------------------------------------------------------------
  // Requests toward the arbitration logic
  // --------------------------------------------------------------------------

  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_irq_req5 <= '0;
      o_irq_req6 <= '0;
      o_irq_req7 <= '0;
      o_irq_req0 <= '0;
      o_irq_req1 <= '0;
    end
    else
    begin
      o_irq_req5 <= reg_q[0] & i_far_enable5; // R18
      o_irq_req6 <= reg_q[1] & i_far_enable6; // R18
      o_irq_req7 <= reg_q[2] & i_far_enable7; // R18
      o_irq_req0 <= i_far_flag0 & reg_q[3]; // R02
      o_irq_req1 <= i_far_flag1 & reg_q[4]; // R02
    end
  end
endmodule
`default_nettype wire

/* File: bench/ife_irq_regs_checker.sv */
// Port-level assertions for the flag/enable register block
`timescale 1ns/100ps
`default_nettype none
`include "ife_irq_regs.svh"
module ife_irq_regs_checker (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire ife_pkg::ife_addr_t i_paddr,
  input wire ife_pkg::ife_data_t i_pwdata,
  input wire ife_pkg::ife_data_t o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire ife_pkg::ife_half_t i_flag_set5,
  input wire ife_pkg::ife_half_t i_far_enable5,
  input wire ife_pkg::ife_half_t i_far_flag0,
  input wire ife_pkg::ife_half_t o_flag5,
  input wire ife_pkg::ife_half_t o_flag7,
  input wire ife_pkg::ife_half_t o_enable0,
  input wire ife_pkg::ife_half_t o_irq_req5,
  input wire ife_pkg::ife_half_t o_irq_req0
);
  import ife_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire logic wr_ec0 = i_psel && i_penable && i_pwrite && (i_paddr == `IFE_OFF_ENABLE_CTRL_0);
  ife_half_t set5_q;
  ife_half_t req5_q;
  ife_half_t req0_q;
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      set5_q <= '0;
      req5_q <= '0;
      req0_q <= '0;
    end
    else
    begin
      set5_q <= i_flag_set5 & `IFE_MASK_FLAG_STATUS_5;
      req5_q <= o_flag5 & i_far_enable5;
      req0_q <= i_far_flag0 & o_enable0;
    end
  end
  property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_acc; o_pready |-> i_psel && i_penable; endproperty
  a_acc: assert property (p_acc) else $error("pready outside access");
  property p_err; o_pslverr |-> o_pready && (i_pwrite || o_prdata == 32'h0); endproperty
  a_err: assert property (p_err) else $error("bad refused read");
  property p_up; o_pready |-> o_prdata[31:16] == 16'h0000; endproperty
  a_up: assert property (p_up) else $error("upper half set");
  property p_set; |i_flag_set5 |=> (o_flag5 & set5_q) == set5_q; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_unused;
    ((o_flag5 & ~`IFE_MASK_FLAG_STATUS_5) | (o_flag7 & ~`IFE_MASK_FLAG_STATUS_7)) == 16'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_req; (o_irq_req5 == req5_q) && (o_irq_req0 == req0_q); endproperty
  a_req: assert property (p_req) else $error("request mismatch");
  property p_wr;
    wr_ec0 && o_pready |=> o_enable0 == ($past(i_pwdata[15:0]) & `IFE_MASK_ENABLE_CTRL_0);
  endproperty
  a_wr: assert property (p_wr) else $error("enable write lost");
  property p_hold; !wr_ec0 |=> $stable(o_enable0); endproperty
  a_hold: assert property (p_hold) else $error("enable changed");
endmodule
bind ife_irq_regs ife_irq_regs_checker u_chk (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_flag_set5(i_flag_set5), .i_far_enable5(i_far_enable5), .i_far_flag0(i_far_flag0),
  .o_flag5(o_flag5), .o_flag7(o_flag7), .o_enable0(o_enable0), .o_irq_req5(o_irq_req5),
  .o_irq_req0(o_irq_req0));
`default_nettype wire

/* File: bench/ife_src_model.sv */
// Event sources and far interrupt logic beside the register block
`timescale 1ns/100ps
`default_nettype none
module ife_src_model (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_fire,
  input wire logic [1:0] i_which,
  input wire ife_pkg::ife_half_t i_pattern,
  input wire ife_pkg::ife_half_t i_level,
  output var ife_pkg::ife_half_t o_set5,
  output var ife_pkg::ife_half_t o_set6,
  output var ife_pkg::ife_half_t o_set7,
  output var ife_pkg::ife_half_t o_level
);
  import ife_pkg::*;
  ife_half_t set_q;
  ife_half_t lvl_q;
  logic [1:0] sel_q;
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      set_q <= '0;
      lvl_q <= '0;
      sel_q <= '0;
    end
    else
    begin
      set_q <= i_fire ? i_pattern : '0;
      lvl_q <= i_level;
      sel_q <= i_which;
    end
  end
  // One-cycle event pulse to the chosen flag register
  assign o_set5 = (sel_q == 2'd0) ? set_q : '0;
  assign o_set6 = (sel_q == 2'd1) ? set_q : '0;
  assign o_set7 = (sel_q == 2'd2) ? set_q : '0;
  assign o_level = lvl_q;
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking testbench for the flag/enable register block
`timescale 1ns/100ps
`default_nettype none
`include "ife_irq_regs.svh"
module testbench;
  import ife_pkg::*;
  localparam ife_addr_t ADR [5] = '{`IFE_OFF_FLAG_STATUS_5, `IFE_OFF_FLAG_STATUS_6,
    `IFE_OFF_FLAG_STATUS_7, `IFE_OFF_ENABLE_CTRL_0, `IFE_OFF_ENABLE_CTRL_1};
  localparam ife_half_t MSK [5] = '{`IFE_MASK_FLAG_STATUS_5, `IFE_MASK_FLAG_STATUS_6,
    `IFE_MASK_FLAG_STATUS_7, `IFE_MASK_ENABLE_CTRL_0, `IFE_MASK_ENABLE_CTRL_1};
  logic clk, rst, psel, pen, pwr, fire, pready, pslverr, err;
  logic [1:0] which;
  ife_addr_t paddr;
  ife_data_t pwdata, prdata, rd;
  ife_half_t pat, lvl, s5, s6, s7, lv;
  ife_half_t flg [5];
  ife_half_t req [5];
  int num_errors = 0;
  int compares = 0;
  ife_src_model u_src (.i_core_clk(clk), .i_reset(rst), .i_fire(fire), .i_which(which),
    .i_pattern(pat), .i_level(lvl), .o_set5(s5), .o_set6(s6), .o_set7(s7), .o_level(lv));
  ife_irq_regs DUT (.i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_flag_set5(s5), .i_flag_set6(s6),
    .i_flag_set7(s7), .i_far_enable5(lv), .i_far_enable6(lv), .i_far_enable7(lv),
    .i_far_flag0(lv), .i_far_flag1(lv), .o_flag5(flg[0]), .o_flag6(flg[1]),
    .o_flag7(flg[2]), .o_enable0(flg[3]), .o_enable1(flg[4]), .o_irq_req5(req[0]),
    .o_irq_req6(req[1]), .o_irq_req7(req[2]), .o_irq_req0(req[3]), .o_irq_req1(req[4]));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input ife_data_t got, input ife_data_t exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input ife_addr_t a, input ife_data_t d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    {psel, pen, pwr, fire, which, paddr, pwdata, pat, lvl} = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      bus(1'b0, ADR[k], 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, ADR[k], 32'hffffffff);
      bus(1'b0, ADR[k], 32'h0);
      chk(rd, {16'h0, MSK[k]});
      lvl <= 16'hffff;
      repeat (3) @(posedge clk);
      chk(req[k], MSK[k]);
      lvl <= 16'h0000;
      repeat (3) @(posedge clk);
      chk(req[k], 32'h0);
      bus(1'b1, ADR[k], 32'h0);
      @(posedge clk);
      chk(flg[k], 32'h0);
    end
    lvl <= 16'haaaa;
    for (int k = 0; k < 3; k++)
      for (int b = 0; b < 16; b++)
      begin
        which <= k[1:0];
        pat <= 16'h1 << b;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (3) @(posedge clk);
        chk(flg[k], (16'h1 << b) & MSK[k]);
        chk(req[k], (16'h1 << b) & MSK[k] & 16'haaaa);
        bus(1'b0, ADR[k], 32'h0);
        chk(rd, {16'h0, (16'h1 << b) & MSK[k]});
        bus(1'b1, ADR[k], 32'h0);
      end
    bus(1'b1, 12'h014, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    bus(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    give_verdict;
  end
  initial
  begin
    #100000;
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
